// ---- pkg/autoneg_regs_pkg.sv ----
// constants for the autonegotiation, next-page and gigabit register group
package autoneg_regs_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_LP_BASE = 6'h05;
   localparam logic [5:0] IDX_EXPAN = 6'h06;
   localparam logic [5:0] IDX_NP_TX = 6'h07;
   localparam logic [5:0] IDX_NP_RX = 6'h08;
   localparam logic [5:0] IDX_GIG_CTRL = 6'h09;
   localparam logic [5:0] IDX_GIG_STAT = 6'h0A;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // partner base page: bit 12 is reserved
   localparam logic [15:0] LP_BASE_MASK = 16'hEFFF;
   localparam logic [15:0] LP_BASE_RST = 16'h0000;
   localparam logic [15:0] NP_RX_RST = 16'h0000;
   // expansion field positions
   localparam int EXP_PD_FAULT = 4;
   localparam int EXP_LP_NP = 3;
   localparam int EXP_LOC_NP = 2;
   localparam int EXP_PAGE_RX = 1;
   localparam int EXP_LP_AN = 0;
   localparam logic EXP_LOC_NP_RST = 1'b1;
   // next-page transmit fields and reset values
   localparam int NPT_MORE = 15;
   localparam int NPT_MSG = 13;
   localparam int NPT_ACK2 = 12;
   localparam int NPT_TOGGLE = 11;
   localparam logic NPT_MSG_RST = 1'b1;
   localparam logic [10:0] NPT_CODE_RST = 11'h001;
   // gigabit control: test mode 15:13, manual 12, value 11, port 10, fdx 9, hdx 8
   localparam logic [15:0] GIG_CTRL_RST = 16'h0700;
   localparam logic [2:0] TM_NORMAL = 3'h0;
   localparam logic [2:0] TM_LAST = 3'h4;
   localparam int GC_MANUAL = 12;
   localparam int GC_VALUE = 11;
   localparam int GC_PORT = 10;
   localparam int GC_FDX = 9;
   localparam int GC_HDX = 8;
   // gigabit status
   localparam logic GS_MASTER_RST = 1'b1;
   localparam logic [7:0] IDLE_MAX = 8'hFF;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- logic/autoneg_partner_nextpage_gig_regs.sv ----
// autonegotiation partner, next-page and 1000BASE-T register group behind AXI4-Lite
// Behaviour
// - partner base page read-only, resets zero
// - bits 11,10 partner asymmetric/symmetric pause
// - bits 9:5 partner T4, TX, 10T abilities
// - parallel fault latches high until read
// - page received flag, cleared by read
// - partner and local next-page support bits
// - bit 0 partner autonegotiation capable
// - writable next-page fields with reset values
// - toggle is inverse of last sent toggle
// - partner next-page receive word, read-only
// - test mode select, reserved codes 101-111
// - manual master/slave, value gated by enable
// - gigabit duplex advertisements reset one
// - master/slave fault latches high until read
// - resolved role captured at each resolution strobe, resets master
// - local and remote receiver status
// - partner gigabit abilities, bits 9:8 zero
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
module autoneg_partner_nextpage_gig_regs
   import autoneg_regs_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [autoneg_regs_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   // axi4-lite write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [autoneg_regs_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [autoneg_regs_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   // axi4-lite read data
   output logic rvalid,
   input wire logic rready,
   output logic [autoneg_regs_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   // partner pages from the negotiation logic
   input wire logic lp_base_strobe,
   input wire logic [15:0] lp_base_word,
   input wire logic lp_np_strobe,
   input wire logic [15:0] lp_np_word,
   input wire logic lp_an_able,
   input wire logic lp_np_able,
   input wire logic pd_fault_event,
   // transmitted link code word
   input wire logic lcw_sent,
   input wire logic lcw_sent_toggle,
   // gigabit pcs status
   input wire logic ms_fault_event,
   input wire logic ms_resolve_strobe,
   input wire logic ms_resolve_master,
   input wire logic local_rx_ok,
   input wire logic remote_rx_ok,
   input wire logic lp_gig_full_duplex,
   input wire logic lp_gig_half_duplex,
   input wire logic idle_error,
   // control toward the negotiation and gigabit logic
   output logic [15:0] np_tx_word,
   output logic [2:0] tx_test_mode,
   output logic ms_force_master,
   output logic ms_force_slave,
   output logic port_multi,
   output logic adv_gig_full_duplex,
   output logic adv_gig_half_duplex
);
   import autoneg_regs_pkg::*;

   logic aw_got_r;
   logic w_got_r;
   logic [ADDR_W-1:0] awaddr_r;
   logic [15:0] wdata_r;
   logic [1:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;
   logic [15:0] lp_base_r;
   logic [15:0] np_rx_r;
   logic pd_fault_r;
   logic page_rcvd_r;
   logic lp_an_able_r;
   logic lp_np_able_r;
   logic np_more_r;
   logic np_msg_r;
   logic np_ack2_r;
   logic np_toggle_r;
   logic [10:0] np_code_r;
   logic [15:0] gig_ctrl_r;
   logic ms_fault_r;
   logic ms_master_r;
   logic local_rx_r;
   logic remote_rx_r;
   logic lp_gfd_r;
   logic lp_ghd_r;
   logic [7:0] idle_cnt_r;

   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic wr_fire;
   logic [5:0] wr_idx;
   logic [5:0] ar_idx;
   logic [15:0] wr_data;
   logic [1:0] wr_strb;
   logic rd_clr_exp;
   logic rd_clr_gig;
   logic [15:0] exp_word;
   logic [15:0] np_tx_rd;
   logic [15:0] gig_stat_word;
   logic [15:0] rd_word;
   logic rd_hit;
   logic wr_hit;

   // byte-lane merge for the low two lanes; upper lanes hold nothing
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw, input logic [1:0] st);
      merge16 = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
   endfunction

   // ---------------- write channel ----------------
   // address and data are latched independently so they may arrive in either order
   assign awready = ~aw_got_r & ~bvalid_r;
   assign wready = ~w_got_r & ~bvalid_r;
   assign aw_hs = awvalid & awready;
   assign w_hs = wvalid & wready;
   assign wr_fire = (aw_got_r | aw_hs) & (w_got_r | w_hs);
   assign wr_idx = aw_got_r ? awaddr_r[7:2] : awaddr[7:2];
   assign wr_data = w_got_r ? wdata_r : wdata[15:0];
   assign wr_strb = w_got_r ? wstrb_r : wstrb[1:0];
   assign wr_hit = (wr_idx >= IDX_LP_BASE) && (wr_idx <= IDX_GIG_STAT);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= 16'h0000;
         wstrb_r <= 2'h0;
      end else begin
         if (wr_fire) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
         end else begin
            if (aw_hs) begin
               aw_got_r <= 1'b1;
               awaddr_r <= awaddr;
            end
            if (w_hs) begin
               w_got_r <= 1'b1;
               wdata_r <= wdata[15:0];
               wstrb_r <= wstrb[1:0];
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_r <= 1'b0;
      end
   end

   assign bvalid = bvalid_r;
   assign bresp = bresp_r;

   // ---------------- read channel ----------------
   // one read in flight; a read of a latched register clears it in the same edge the data is captured
   assign arready = ~rvalid_r;
   assign ar_hs = arvalid & arready;
   assign ar_idx = araddr[7:2];
   assign rd_clr_exp = ar_hs && (ar_idx == IDX_EXPAN);
   assign rd_clr_gig = ar_hs && (ar_idx == IDX_GIG_STAT);

   assign exp_word = {11'h000, pd_fault_r, lp_np_able_r, EXP_LOC_NP_RST, page_rcvd_r, lp_an_able_r};
   assign np_tx_rd = {np_more_r, 1'b0, np_msg_r, np_ack2_r, np_toggle_r, np_code_r};
   assign gig_stat_word = {ms_fault_r, ms_master_r, local_rx_r, remote_rx_r,
                           lp_gfd_r, lp_ghd_r, 2'b00, idle_cnt_r};

   always_comb begin
      rd_word = 16'h0000;
      rd_hit = 1'b1;
      unique case (ar_idx)
         IDX_LP_BASE: rd_word = lp_base_r;
         IDX_EXPAN: rd_word = exp_word;
         IDX_NP_TX: rd_word = np_tx_rd;
         IDX_NP_RX: rd_word = np_rx_r;
         IDX_GIG_CTRL: rd_word = gig_ctrl_r;
         IDX_GIG_STAT: rd_word = gig_stat_word;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_r <= 1'b1;
         rdata_r <= {16'h0000, rd_word};
         rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   // ---------------- partner pages ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lp_base_r <= LP_BASE_RST;
      end else if (lp_base_strobe) begin
         lp_base_r <= lp_base_word & LP_BASE_MASK;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         np_rx_r <= NP_RX_RST;
      end else if (lp_np_strobe) begin
         np_rx_r <= lp_np_word;
      end
   end

   // a new page of either kind raises the flag; an arriving page beats a clearing read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         page_rcvd_r <= 1'b0;
      end else if (lp_base_strobe | lp_np_strobe) begin
         page_rcvd_r <= 1'b1;
      end else if (rd_clr_exp) begin
         page_rcvd_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pd_fault_r <= 1'b0;
      end else if (pd_fault_event) begin
         pd_fault_r <= 1'b1;
      end else if (rd_clr_exp) begin
         pd_fault_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lp_an_able_r <= 1'b0;
         lp_np_able_r <= 1'b0;
      end else begin
         lp_an_able_r <= lp_an_able;
         lp_np_able_r <= lp_np_able;
      end
   end

   // ---------------- next-page transmit ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         np_more_r <= 1'b0;
         np_msg_r <= NPT_MSG_RST;
         np_ack2_r <= 1'b0;
         np_code_r <= NPT_CODE_RST;
      end else if (wr_fire && wr_idx == IDX_NP_TX) begin
         if (wr_strb[1]) begin
            np_more_r <= wr_data[NPT_MORE];
            np_msg_r <= wr_data[NPT_MSG];
            np_ack2_r <= wr_data[NPT_ACK2];
         end
         np_code_r <= {wr_strb[1] ? wr_data[10:8] : np_code_r[10:8], wr_strb[0] ? wr_data[7:0] : np_code_r[7:0]};
      end
   end

   // the toggle follows the link, never software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         np_toggle_r <= 1'b0;
      end else if (lcw_sent) begin
         np_toggle_r <= ~lcw_sent_toggle;
      end
   end

   assign np_tx_word = np_tx_rd;

   // ---------------- gigabit control ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gig_ctrl_r <= GIG_CTRL_RST;
      end else if (wr_fire && wr_idx == IDX_GIG_CTRL) begin
         gig_ctrl_r <= merge16(gig_ctrl_r, wr_data, wr_strb);
      end
   end

   // reserved test codes read back as written but drive the transmitter as normal;
   // media sense must already be off before software picks a test code
   assign tx_test_mode = (gig_ctrl_r[15:13] > TM_LAST) ? TM_NORMAL : gig_ctrl_r[15:13];
   assign ms_force_master = gig_ctrl_r[GC_MANUAL] & gig_ctrl_r[GC_VALUE];
   assign ms_force_slave = gig_ctrl_r[GC_MANUAL] & ~gig_ctrl_r[GC_VALUE];
   assign port_multi = gig_ctrl_r[GC_PORT];
   assign adv_gig_full_duplex = gig_ctrl_r[GC_FDX];
   assign adv_gig_half_duplex = gig_ctrl_r[GC_HDX];

   // ---------------- gigabit status ----------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_fault_r <= 1'b0;
      end else if (ms_fault_event) begin
         ms_fault_r <= 1'b1;
      end else if (rd_clr_gig) begin
         ms_fault_r <= 1'b0;
      end
   end

   // the role is taken only at resolution, so later timing swaps leave it alone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ms_master_r <= GS_MASTER_RST;
      end else if (ms_resolve_strobe) begin
         ms_master_r <= ms_resolve_master;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         local_rx_r <= 1'b0;
         remote_rx_r <= 1'b0;
         lp_gfd_r <= 1'b0;
         lp_ghd_r <= 1'b0;
      end else begin
         local_rx_r <= local_rx_ok;
         remote_rx_r <= remote_rx_ok;
         lp_gfd_r <= lp_gig_full_duplex;
         lp_ghd_r <= lp_gig_half_duplex;
      end
   end

   // an error in the clearing cycle restarts the count at one rather than being lost
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idle_cnt_r <= 8'h00;
      end else if (rd_clr_gig) begin
         idle_cnt_r <= idle_error ? 8'h01 : 8'h00;
      end else if (idle_error && idle_cnt_r != IDLE_MAX) begin
         idle_cnt_r <= idle_cnt_r + 8'h01;
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence rd_exp_s;
      ar_hs && ar_idx == IDX_EXPAN;
   endsequence

   sequence rd_gig_s;
      ar_hs && ar_idx == IDX_GIG_STAT;
   endsequence

   AST_BASE_LOAD: assert property (lp_base_strobe |=> lp_base_r == ($past(lp_base_word) & LP_BASE_MASK))
      else $error("partner base page not loaded");
   AST_PD_FAULT_HOLD: assert property (pd_fault_event |=> pd_fault_r ##1 (pd_fault_r || $past(rd_clr_exp)))
      else $error("parallel fault flag dropped without read");
   AST_EXP_READ: assert property (rd_exp_s |=> rvalid && rdata[15:5] == 11'h000 && rdata[2])
      else $error("expansion reserved or local bit wrong");
   AST_PAGE_CLR: assert property ((rd_exp_s and !lp_base_strobe and !lp_np_strobe) |=> !page_rcvd_r)
      else $error("page flag not cleared by read");
   AST_TOGGLE: assert property (lcw_sent |=> np_toggle_r == !$past(lcw_sent_toggle))
      else $error("toggle is not inverse of sent value");
   AST_NP_RX: assert property (lp_np_strobe |=> np_rx_r == $past(lp_np_word) && page_rcvd_r)
      else $error("next-page receive word not loaded");
   AST_MS_GATED: assert property (!gig_ctrl_r[GC_MANUAL] |-> !ms_force_master && !ms_force_slave)
      else $error("master/slave forced without manual enable");
   AST_TEST_MODE: assert property (gig_ctrl_r[15:13] > TM_LAST |-> tx_test_mode == TM_NORMAL)
      else $error("reserved test code reached transmitter");
   AST_MS_FAULT: assert property (ms_fault_event |=> ms_fault_r)
      else $error("master/slave fault not latched");
   AST_IDLE_SAT: assert property ((idle_cnt_r == IDLE_MAX && !rd_clr_gig) |=> idle_cnt_r == IDLE_MAX)
      else $error("idle error count wrapped");
   AST_GIG_READ: assert property (rd_gig_s ##1 !rd_clr_gig |-> rdata[9:8] == 2'b00)
      else $error("gigabit status reserved bits set");
   AST_ROLE_HOLD: assert property (!ms_resolve_strobe |=> $stable(ms_master_r))
      else $error("resolved role changed without resolution");
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the autonegotiation, next-page and gigabit register group
`timescale 1ns/1ns
module tb_top;
   import autoneg_regs_pkg::*;
   logic aclk = 0;
   logic aresetn = 0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [3:0] wstrb = 0;
   logic lp_base_strobe = 0, lp_np_strobe = 0, lp_an_able = 0, lp_np_able = 0, pd_fault_event = 0;
   logic lcw_sent = 0, lcw_sent_toggle = 0, ms_fault_event = 0, ms_resolve_strobe = 0, ms_resolve_master = 0;
   logic local_rx_ok = 0, remote_rx_ok = 0, lp_gig_full_duplex = 0, lp_gig_half_duplex = 0, idle_error = 0;
   logic [15:0] lp_base_word = 0, lp_np_word = 0, rnd = 16'h0042, w;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] np_tx_word;
   logic [2:0] tx_test_mode;
   logic ms_force_master, ms_force_slave, port_multi, adv_gig_full_duplex, adv_gig_half_duplex;
   logic [15:0] rst_tab[6] = '{16'h0000, 16'h0004, 16'h2001, 16'h0000, 16'h0700, 16'h4000};
   // expected responses, oldest first; the monitor below pops them
   logic [1:0] wq[$];
   logic [33:0] rq[$];
   int err_total = 0;
   int checks = 0;
   int cyc = 0;

   autoneg_partner_nextpage_gig_regs DUT (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
      .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
      .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .lp_base_strobe, .lp_base_word, .lp_np_strobe,
      .lp_np_word, .lp_an_able, .lp_np_able, .pd_fault_event, .lcw_sent, .lcw_sent_toggle,
      .ms_fault_event, .ms_resolve_strobe, .ms_resolve_master, .local_rx_ok, .remote_rx_ok,
      .lp_gig_full_duplex, .lp_gig_half_duplex, .idle_error, .np_tx_word, .tx_test_mode,
      .ms_force_master, .ms_force_slave, .port_multi, .adv_gig_full_duplex, .adv_gig_half_duplex);

   always #20 aclk = ~aclk;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // handshakes are judged on values settled before the rising edge, acted on right after it
   task automatic wr(input logic [5:0] idx, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ta, tw, tb;
      wq.push_back(er);
      @(posedge aclk);
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      awaddr <= {idx, 2'h0};
      wdata <= {16'h0, d};
      wstrb <= s;
      do begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         @(posedge aclk);
         if (ta)
            awvalid <= 0;
         if (tw)
            wvalid <= 0;
      end while (!tb);
      bready <= 0;
   endtask

   task automatic rd(input logic [5:0] idx, input logic [15:0] d, input logic [1:0] er);
      logic ta, tr;
      rq.push_back({er, 16'h0, d});
      @(posedge aclk);
      arvalid <= 1;
      rready <= 1;
      araddr <= {idx, 2'h0};
      do begin
         @(negedge aclk);
         ta = arvalid && arready;
         tr = rvalid && rready;
         @(posedge aclk);
         if (ta)
            arvalid <= 0;
      end while (!tr);
      rready <= 0;
   endtask

   always @(posedge aclk) begin
      if (bvalid && bready)
         chk({32'h0, bresp}, {32'h0, wq.pop_front()}, "write response");
      if (rvalid && rready)
         chk({rresp, rdata}, rq.pop_front(), "read data");
   end

   // the whole sequence needs well under a thousand cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         err_total++;
         $display("CHECK FAILED at %0t: run did not finish in time", $time);
         give_verdict;
      end
   end

   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      @(negedge aclk);
      chk({np_tx_word, tx_test_mode, ms_force_master, ms_force_slave, port_multi, adv_gig_full_duplex,
         adv_gig_half_duplex}, {16'h2001, 3'h0, 5'b00111}, "reset outputs");
      for (int i = 0; i < 6; i++)
         rd(6'(5 + i), rst_tab[i], RESP_OKAY);
      rd(6'h3F, 16'h0000, RESP_SLVERR);
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         @(posedge aclk);
         lp_base_word <= rnd;
         lp_base_strobe <= 1;
         @(posedge aclk);
         lp_base_strobe <= 0;
         lp_base_word <= ~rnd;
         wr(IDX_LP_BASE, ~rnd, 4'hF, RESP_OKAY);
         rd(IDX_LP_BASE, rnd & 16'hEFFF, RESP_OKAY);
         rd(IDX_EXPAN, 16'h0006, RESP_OKAY);
         rd(IDX_EXPAN, 16'h0004, RESP_OKAY);
      end
      $display("test partner base page done");
      @(posedge aclk);
      pd_fault_event <= 1;
      lp_an_able <= 1;
      lp_np_able <= 1;
      @(posedge aclk);
      pd_fault_event <= 0;
      rd(IDX_EXPAN, 16'h001D, RESP_OKAY);
      rd(IDX_EXPAN, 16'h000D, RESP_OKAY);
      lp_an_able <= 0;
      lp_np_able <= 0;
      rd(IDX_EXPAN, 16'h0004, RESP_OKAY);
      rnd = lfsr(rnd);
      @(posedge aclk);
      lp_np_word <= rnd | 16'h4000;
      lp_np_strobe <= 1;
      @(posedge aclk);
      lp_np_strobe <= 0;
      rd(IDX_NP_RX, rnd | 16'h4000, RESP_OKAY);
      rd(IDX_EXPAN, 16'h0006, RESP_OKAY);
      $display("test expansion and next page receive done");
      wr(IDX_NP_TX, 16'h0000, 4'h3, RESP_OKAY);
      wr(IDX_NP_TX, 16'hFFFF, 4'h1, RESP_OKAY);
      rd(IDX_NP_TX, 16'h00FF, RESP_OKAY);
      wr(IDX_NP_TX, 16'hFFFF, 4'h3, RESP_OKAY);
      for (int t = 0; t < 2; t++) begin
         @(posedge aclk);
         lcw_sent <= 1;
         lcw_sent_toggle <= t[0];
         @(posedge aclk);
         lcw_sent <= 0;
         lcw_sent_toggle <= ~t[0];
         rd(IDX_NP_TX, t ? 16'hB7FF : 16'hBFFF, RESP_OKAY);
         chk(np_tx_word, t ? 16'hB7FF : 16'hBFFF, "next page word out");
      end
      $display("test next page transmit done");
      for (int m = 0; m < 8; m++) begin
         rnd = lfsr(rnd);
         w = {m[2:0], m[1:0], m[2:0], rnd[7:0]};
         wr(IDX_GIG_CTRL, w, 4'h3, RESP_OKAY);
         wr(6'h20, ~w, 4'hF, RESP_SLVERR);
         rd(IDX_GIG_CTRL, w, RESP_OKAY);
         @(negedge aclk);
         chk({tx_test_mode, ms_force_master, ms_force_slave, port_multi, adv_gig_full_duplex, adv_gig_half_duplex},
            {(m < 5) ? m[2:0] : 3'h0, w[12] & w[11], w[12] & ~w[11], w[10:8]}, "control outputs");
      end
      $display("test gigabit control done");
      @(posedge aclk);
      ms_fault_event <= 1;
      ms_resolve_strobe <= 1;
      local_rx_ok <= 1;
      lp_gig_full_duplex <= 1;
      idle_error <= 1;
      repeat (3) @(posedge aclk);
      ms_fault_event <= 0;
      ms_resolve_strobe <= 0;
      idle_error <= 0;
      ms_resolve_master <= 1;
      rd(IDX_GIG_STAT, 16'hA803, RESP_OKAY);
      rd(IDX_GIG_STAT, 16'h2800, RESP_OKAY);
      remote_rx_ok <= 1;
      local_rx_ok <= 0;
      lp_gig_full_duplex <= 0;
      lp_gig_half_duplex <= 1;
      idle_error <= 1;
      repeat (300) @(posedge aclk);
      idle_error <= 0;
      rd(IDX_GIG_STAT, 16'h14FF, RESP_OKAY);
      wr(IDX_GIG_STAT, 16'hFFFF, 4'hF, RESP_OKAY);
      rd(IDX_GIG_STAT, 16'h1400, RESP_OKAY);
      $display("test gigabit status done");
      @(posedge aclk);
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(IDX_NP_TX, 16'h2001, RESP_OKAY);
      rd(IDX_GIG_STAT, 16'h5400, RESP_OKAY);
      $display("test second reset done");
      repeat (2) @(posedge aclk);
      chk(wq.size() + rq.size(), 0, "responses outstanding");
      give_verdict;
   end
endmodule
